// ==== rtl/floppy_command_head_rw_control.sv ====
// Command decode, head engage, read clock recovery and write serialiser.
// Assumes synchronous host strobes; stepping, CRC and ID search lie outside.
`timescale 1ns/1ps
module floppy_command_head_rw_control
   import fdc_pkg::*;
(
   input wire logic clock,
   input wire logic resetn,
   input wire logic clk_en,
   input wire logic cmd_wr,
   input wire logic [7:0] cmd_word,
   input wire logic status_rd,
   input wire logic data_wr,
   input wire logic [7:0] data_in,
   input wire logic data_rd,
   input wire logic step_done,
   input wire logic op_done,
   input wire logic mark_found,
   input wire logic [7:0] length_indicator,
   input wire logic index_pulse,
   input wire logic ready_in,
   input wire logic write_protect_n,
   input wire logic write_fault,
   input wire logic head_settled_in,
   input wire logic disk_read_serial_in,
   input wire logic external_separator_select,
   input wire logic read_clock_in,
   output logic head_engage_out,
   output logic write_gate_out,
   output logic serial_write_out,
   output logic interrupt_request_out,
   output logic byte_request_out,
   output logic [7:0] status_out,
   output logic [7:0] data_out,
   output logic [7:0] data_mark_out,
   output logic [12:0] sector_len_out,
   output logic [1:0] step_rate_select,
   output logic data_clock_out
);
   // ----------------------------------------
   // Command decode
   // ----------------------------------------
   logic is_restore, is_seek, is_step, is_read, is_write, is_force, is_rw, is_pos, is_t3;
   always_comb begin
      is_restore = cmd_word[7:4] == OP_RESTORE;
      is_seek = cmd_word[7:4] == OP_SEEK;
      is_step = cmd_word[7:5] == OP_STEP || cmd_word[7:5] == OP_STEP_IN
         || cmd_word[7:5] == OP_STEP_OUT;
      is_read = cmd_word[7:5] == OP_READ;
      is_write = cmd_word[7:5] == OP_WRITE;
      is_force = cmd_word[7:4] == OP_FORCE_INT;
      is_t3 = cmd_word[7:4] == OP_READ_ADDR || cmd_word[7:4] == OP_READ_TRACK
         || cmd_word[7:4] == OP_WRITE_TRACK;
      is_rw = is_read || is_write;
      is_pos = is_restore || is_seek || is_step;
   end

   // ----------------------------------------
   // Control state
   // ----------------------------------------
   ctl_state_t state_ff, nxt_state;
   logic [7:0] cmd_ff, nxt_cmd, status_ff, nxt_status, dreg_ff, nxt_dreg, mark_ff, nxt_mark;
   logic [7:0] shift_ff, nxt_shift;
   logic [23:0] settle_ff, nxt_settle;
   logic [12:0] len_ff, nxt_len;
   logic [1:0] idx_ff, nxt_idx;
   logic head_ff, nxt_head, gate_ff, nxt_gate, irq_ff, nxt_irq, req_ff, nxt_req;
   logic loaded_ff, nxt_loaded, writing, byte_done, byte_need;

   // Head, busy, interrupt, request and data register
   always_comb begin
      nxt_state = state_ff;
      nxt_cmd = cmd_ff;
      nxt_status = status_ff;
      nxt_settle = settle_ff;
      nxt_idx = idx_ff;
      nxt_head = head_ff;
      nxt_gate = gate_ff;
      nxt_irq = irq_ff;
      nxt_req = req_ff;
      nxt_loaded = loaded_ff;
      nxt_dreg = dreg_ff;
      nxt_mark = mark_ff;
      nxt_len = len_ff;
      writing = cmd_ff[7:5] == OP_WRITE;
      if (status_rd)
         nxt_irq = 1'b0;
      if (data_rd && !writing)
         nxt_req = 1'b0;
      if (data_wr) begin
         nxt_dreg = data_in;
         nxt_loaded = 1'b1;
         if (writing)
            nxt_req = 1'b0;
      end
      // Head release after third idle index pulse
      if (state_ff == S_IDLE && head_ff && index_pulse) begin
         nxt_idx = idx_ff + 2'h1;
         if (idx_ff == 2'(INDEX_RELEASE - 1))
            nxt_head = 1'b0;
      end
      case (state_ff)
         S_IDLE: begin
            if (cmd_wr && !is_force) begin
               nxt_cmd = cmd_word;
               nxt_irq = 1'b0;
               nxt_idx = 2'h0;
               nxt_loaded = 1'b0;
               nxt_req = 1'b0;
               nxt_status = 8'h00;
               nxt_mark = cmd_word[1:0] == 2'h0 ? MARK_FB :
                  cmd_word[1:0] == 2'h1 ? MARK_FA :
                  cmd_word[1:0] == 2'h2 ? MARK_F9 : MARK_F8;
               if (is_rw && !ready_in) begin
                  nxt_irq = 1'b1;
                  nxt_status[ST_NRDY] = 1'b1;
               end else if (is_write && !write_protect_n) begin
                  nxt_irq = 1'b1;
                  nxt_status[ST_PROT] = 1'b1;
               end else if (is_pos) begin
                  nxt_status[ST_BUSY] = 1'b1;
                  nxt_head = cmd_word[B_LOAD];
                  nxt_state = S_STEP;
               end else if (is_rw || is_t3) begin
                  nxt_status[ST_BUSY] = 1'b1;
                  if (is_rw && !cmd_word[B_ENGAGE] && head_ff)
                     nxt_state = is_write ? S_WAIT_BYTE : S_READ;
                  else begin
                     nxt_head = 1'b1;
                     nxt_settle = 24'(SETTLE_CYC);
                     nxt_state = S_SETTLE;
                  end
               end
            end else if (cmd_wr)
               nxt_irq = 1'b1;
         end
         S_STEP: if (step_done) begin
            if (cmd_ff[B_VERIFY]) begin
               nxt_head = 1'b1;
               nxt_settle = 24'(SETTLE_CYC);
               nxt_state = S_SETTLE;
            end else begin
               nxt_status[ST_BUSY] = 1'b0;
               nxt_irq = 1'b1;
               nxt_state = S_IDLE;
            end
         end
         S_SETTLE: if (settle_ff != 24'h0)
            nxt_settle = settle_ff - 24'h1;
         else if (head_settled_in)
            nxt_state = writing ? S_WAIT_BYTE : S_READ;
         S_WAIT_BYTE: begin
            nxt_req = !data_wr;
            if (loaded_ff) begin
               nxt_gate = 1'b1;
               nxt_loaded = data_wr; // First byte moves to the shifter
               nxt_state = S_WRITE;
            end
         end
         S_READ, S_WRITE: begin
            if (op_done) begin
               nxt_status[ST_BUSY] = 1'b0;
               nxt_irq = 1'b1;
               nxt_gate = 1'b0;
               nxt_state = S_IDLE;
            end
         end
         default: nxt_state = S_IDLE;
      endcase
      // Sector length from block flag
      if (cmd_ff[B_BLOCK])
         nxt_len = LEN_STD << length_indicator[1:0];
      else
         nxt_len = length_indicator == 8'h00 ? LEN_GROUP_MAX :
            {1'b0, length_indicator, 4'h0};
      // Read byte lands in data register
      if (state_ff == S_READ && byte_done) begin
         nxt_dreg = nxt_shift; // Byte including its last bit
         if (req_ff)
            nxt_status[ST_LOST] = 1'b1;
         nxt_req = 1'b1;
      end
      // Write byte taken by serialiser
      if (state_ff == S_WRITE && byte_need) begin
         if (!loaded_ff)
            nxt_status[ST_LOST] = 1'b1;
         nxt_loaded = 1'b0;
         nxt_req = 1'b1;
      end
      // Write fault or write protect ends a write command
      if (state_ff != S_IDLE && writing && (write_fault || !write_protect_n)) begin
         nxt_gate = 1'b0;
         nxt_status[ST_BUSY] = 1'b0;
         nxt_status[write_fault ? ST_FAULT : ST_PROT] = 1'b1;
         nxt_irq = 1'b1;
         nxt_state = S_IDLE;
      end
      if (cmd_wr && is_force) begin
         nxt_gate = 1'b0;
         nxt_status[ST_BUSY] = 1'b0;
         nxt_irq = 1'b1;
         nxt_state = S_IDLE;
      end
      nxt_status[ST_REQ] = nxt_req;
   end

   // ----------------------------------------
   // Data clock and bit path
   // ----------------------------------------
   logic [1:0] div_ff, nxt_div;
   logic [2:0] bit_ff, nxt_bit;
   logic [7:0] wsh_ff, nxt_wsh;
   logic rd_s_ff, rd_p_ff, rclk_p_ff, phase_ff, nxt_phase, wout_ff, nxt_wout, dclk_ff;
   logic toggle, rclk_fall, tick;

   always_comb begin
      toggle = rd_s_ff != rd_p_ff;
      rclk_fall = rclk_p_ff && !read_clock_in;
      nxt_div = div_ff + 2'h1;
      if (state_ff == S_READ && toggle)
         nxt_div = 2'h0;
      else if (state_ff == S_WAIT_BYTE)
         nxt_div = 2'h0; // Write cells open on a clock pulse
      tick = div_ff == 2'(DATA_CLK_DIV - 1);
      nxt_phase = phase_ff;
      nxt_shift = shift_ff;
      nxt_bit = bit_ff;
      nxt_wsh = wsh_ff;
      nxt_wout = 1'b0;
      byte_done = 1'b0;
      byte_need = 1'b0;
      if (mark_found)
         nxt_phase = 1'b1;
      else if (state_ff == S_WAIT_BYTE)
         nxt_phase = 1'b0;
      else if (tick)
         nxt_phase = !phase_ff;
      if (state_ff == S_READ) begin
         if (!external_separator_select) begin
            if (rclk_fall) begin
               nxt_shift = {shift_ff[6:0], disk_read_serial_in};
               nxt_bit = bit_ff + 3'h1;
               byte_done = bit_ff == 3'h7;
            end
         end else if (tick && phase_ff) begin
            nxt_shift = {shift_ff[6:0], toggle};
            nxt_bit = bit_ff + 3'h1;
            byte_done = bit_ff == 3'h7;
         end
      end else if (state_ff == S_WRITE) begin
         if (div_ff == 2'h0)
            nxt_wout = phase_ff ? wsh_ff[7] : 1'b1;
         if (tick && phase_ff) begin
            nxt_wsh = {wsh_ff[6:0], 1'b0};
            nxt_bit = bit_ff + 3'h1;
            if (bit_ff == 3'h7) begin
               byte_need = 1'b1;
               nxt_wsh = loaded_ff ? dreg_ff : 8'h00;
            end
         end
      end else begin
         nxt_bit = 3'h0;
         nxt_wsh = dreg_ff;
      end
   end

   // Register everything under the clock enable
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         state_ff <= S_IDLE;
         cmd_ff <= 8'h00;
         status_ff <= 8'h00;
         settle_ff <= 24'h0;
         idx_ff <= 2'h0;
         head_ff <= 1'b0;
         gate_ff <= 1'b0;
         irq_ff <= 1'b0;
         req_ff <= 1'b0;
         loaded_ff <= 1'b0;
         dreg_ff <= 8'h00;
         mark_ff <= 8'h00;
         len_ff <= 13'h0;
         shift_ff <= 8'h00;
         div_ff <= 2'h0;
         bit_ff <= 3'h0;
         wsh_ff <= 8'h00;
         rd_s_ff <= 1'b0;
         rd_p_ff <= 1'b0;
         rclk_p_ff <= 1'b0;
         phase_ff <= 1'b0;
         wout_ff <= 1'b0;
         dclk_ff <= 1'b0;
      end else if (clk_en) begin
         state_ff <= nxt_state;
         cmd_ff <= nxt_cmd;
         status_ff <= nxt_status;
         settle_ff <= nxt_settle;
         idx_ff <= nxt_idx;
         head_ff <= nxt_head;
         gate_ff <= nxt_gate;
         irq_ff <= nxt_irq;
         req_ff <= nxt_req;
         loaded_ff <= nxt_loaded;
         dreg_ff <= nxt_dreg;
         mark_ff <= nxt_mark;
         len_ff <= nxt_len;
         shift_ff <= nxt_shift;
         div_ff <= nxt_div;
         bit_ff <= nxt_bit;
         wsh_ff <= nxt_wsh;
         rd_s_ff <= disk_read_serial_in;
         rd_p_ff <= rd_s_ff;
         rclk_p_ff <= read_clock_in;
         phase_ff <= nxt_phase;
         wout_ff <= nxt_wout;
         dclk_ff <= nxt_div[1];
      end
   end

   always_comb begin
      head_engage_out = head_ff;
      write_gate_out = gate_ff;
      serial_write_out = wout_ff;
      interrupt_request_out = irq_ff;
      byte_request_out = req_ff;
      status_out = status_ff;
      data_out = dreg_ff;
      data_mark_out = mark_ff;
      sector_len_out = len_ff;
      step_rate_select = cmd_ff[1:0];
      data_clock_out = dclk_ff;
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   gate_needs_byte_a: assert property (@(posedge clock) disable iff (!resetn)
      $rose(gate_ff) |-> $past(loaded_ff)) else $error("write gate before byte");
   fault_drops_gate_a: assert property (@(posedge clock) disable iff (!resetn)
      clk_en && write_fault && writing && state_ff != S_IDLE |=> !gate_ff && status_ff[ST_FAULT])
      else $error("fault did not end write");
   not_ready_a: assert property (@(posedge clock) disable iff (!resetn)
      clk_en && state_ff == S_IDLE && cmd_wr && is_rw && !ready_in |=> state_ff == S_IDLE && irq_ff)
      else $error("not ready command ran");
   head_start_a: assert property (@(posedge clock) disable iff (!resetn)
      clk_en && state_ff == S_IDLE && cmd_wr && is_pos |=> head_ff == $past(cmd_word[B_LOAD]))
      else $error("load flag not applied");
   settle_wait_a: assert property (@(posedge clock) disable iff (!resetn)
      clk_en && state_ff == S_SETTLE && settle_ff != 24'h0 && !(cmd_wr && is_force)
      && !(writing && (write_fault || !write_protect_n)) |=> state_ff == S_SETTLE)
      else $error("settle cut short");
   irq_hold_a: assert property (@(posedge clock) disable iff (!resetn)
      irq_ff && !status_rd && !cmd_wr |=> irq_ff) else $error("irq dropped");
   busy_flag_a: assert property (@(posedge clock) disable iff (!resetn)
      state_ff != S_IDLE |-> status_ff[ST_BUSY]) else $error("busy clear while active");
   req_on_byte_a: assert property (@(posedge clock) disable iff (!resetn)
      clk_en && state_ff == S_READ && byte_done |=> req_ff) else $error("no request");
   cover_write_c: cover property (@(posedge clock) $rose(gate_ff));
   cover_read_c: cover property (@(posedge clock) state_ff == S_READ && byte_done);
   cover_release_c: cover property (@(posedge clock) $fell(head_ff));
endmodule

// ==== rtl/fdc_pkg.sv ====
// Constants, command codes and states for the floppy command and head control block.
// Assumes a single 125 MHz clock; the host and drive sides are plain ports.
// Notes on behaviour
// - Engage head on read, write, verify, loaded step
// - Release head after third index pulse idle
// - Wait 10 ms, then sample head settled
// - Engage-delay flag clear skips settle wait on read or write if head already engaged
// - Verify without load flag engages after stepping
// - Positioning load flag sets or clears engage
// - Divide clock by four, resync on reads
// - Inject clock when no read transition
// - Halve data clock, phase set by mark
// - Sample read input to find toggles
// - External mode: falling read clock shifts data
// - Block flag set: 128 times power of two
// - Block flag clear: sixteen times indicator, zero=4096
// - Clock pulse interlaced between written data bits
// - No write gate before first byte loaded
// - Write protect low ends write, interrupts
// - Write fault ends write command, drops write gate
// - Not ready blocks read or write commands
// - Busy while executing; interrupt on completion
// - Decode eleven commands from upper bits
// - Write mark select chooses FB FA F9 F8
// - Interrupt holds until status read or command
// - Missing write byte writes zeroes, lost data
// - Byte request on read byte, cleared by read
package fdc_pkg;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int unsigned CLK_HZ = 125000000;
   localparam int unsigned SETTLE_MS = 10;
   localparam int unsigned SETTLE_CYC = CLK_HZ / 1000 * SETTLE_MS;
   localparam int unsigned DATA_CLK_DIV = 4;
   localparam int unsigned BIT_CELL_CYC = 2 * DATA_CLK_DIV;
   localparam int unsigned INDEX_RELEASE = 3;
   // ----------------------------------------
   // Command codes
   // ----------------------------------------
   localparam logic [3:0] OP_RESTORE = 4'h0;
   localparam logic [3:0] OP_SEEK = 4'h1;
   localparam logic [2:0] OP_STEP = 3'h1;
   localparam logic [2:0] OP_STEP_IN = 3'h2;
   localparam logic [2:0] OP_STEP_OUT = 3'h3;
   localparam logic [2:0] OP_READ = 3'h4;
   localparam logic [2:0] OP_WRITE = 3'h5;
   localparam logic [3:0] OP_READ_ADDR = 4'hc;
   localparam logic [3:0] OP_FORCE_INT = 4'hd;
   localparam logic [3:0] OP_READ_TRACK = 4'he;
   localparam logic [3:0] OP_WRITE_TRACK = 4'hf;
   // Field positions
   localparam int unsigned B_LOAD = 3;
   localparam int unsigned B_VERIFY = 2;
   localparam int unsigned B_ENGAGE = 2;
   localparam int unsigned B_BLOCK = 3;
   // Status bit positions
   localparam int unsigned ST_BUSY = 0;
   localparam int unsigned ST_REQ = 1;
   localparam int unsigned ST_LOST = 2;
   localparam int unsigned ST_FAULT = 5;
   localparam int unsigned ST_PROT = 6;
   localparam int unsigned ST_NRDY = 7;
   // Data address marks
   localparam logic [7:0] MARK_FB = 8'hfb;
   localparam logic [7:0] MARK_FA = 8'hfa;
   localparam logic [7:0] MARK_F9 = 8'hf9;
   localparam logic [7:0] MARK_F8 = 8'hf8;
   localparam logic [12:0] LEN_STD = 13'h0080;
   localparam logic [12:0] LEN_GROUP_MAX = 13'h1000;
   typedef enum logic [5:0] {
      S_IDLE = 6'h01,
      S_STEP = 6'h02,
      S_SETTLE = 6'h04,
      S_READ = 6'h08,
      S_WAIT_BYTE = 6'h10,
      S_WRITE = 6'h20
   } ctl_state_t;
endpackage

// ==== tb/drive_model.sv ====
// Drive-side model: head settle delay, index pulses, protect and fault levels.
// Assumes the bench drives the request inputs at the falling clock edge.
`timescale 1ns/1ps
module drive_model #(
   parameter int SETTLE_DLY = 6
) (
   input wire logic clock,
   input wire logic resetn,
   input wire logic head_engage_out,
   input wire logic write_gate_out,
   input wire logic protect_req,
   input wire logic fault_req,
   input wire logic index_req,
   output logic head_settled_in,
   output logic write_protect_n,
   output logic write_fault,
   output logic index_pulse
);
   int dly;
   // Head settled rises a fixed delay after engage, drops with it
   always @(negedge clock or negedge resetn) begin
      if (!resetn) begin
         dly <= 0;
         head_settled_in <= 1'b0;
      end else begin
         dly <= head_engage_out ? ((dly < SETTLE_DLY) ? dly + 1 : dly) : 0;
         head_settled_in <= head_engage_out && (dly >= SETTLE_DLY);
      end
   end
   // Fault only shows while write current is gated on
   assign write_fault = fault_req & write_gate_out;
   assign write_protect_n = !protect_req;
   assign index_pulse = index_req;
endmodule

// ==== tb/test_floppy_command_head_rw_control.sv ====
// Self-checking bench for the command, head and read/write control block.
// Assumes fdc_pkg and the drive model in drive_model.sv.
`timescale 1ns/1ps
module test_floppy_command_head_rw_control;
   import fdc_pkg::*;
   logic clock = 1'b0, resetn = 1'b0, cmd_wr = 1'b0, status_rd = 1'b0, data_wr = 1'b0;
   logic data_rd = 1'b0, step_done = 1'b0, mark_found = 1'b0, ready_in = 1'b1;
   logic ext_sel = 1'b1, rd_clk = 1'b1, rd_dat = 1'b0, dprev;
   logic protect_req = 1'b0, fault_req = 1'b0, index_req = 1'b0, op_done = 1'b0;
   logic [7:0] cmd_word = 8'h00, data_in = 8'h00, len_ind = 8'h00;
   logic head_settled_in, write_protect_n, write_fault, index_pulse;
   logic head_engage_out, write_gate_out, serial_write_out, irq, req, data_clock_out;
   logic [7:0] status_out, data_out, data_mark_out;
   logic [12:0] sector_len_out;
   logic [1:0] rate_sel;
   int n_fail = 0, cmp_count = 0, i, k;
   logic [7:0] codes [10] = '{8'h08, 8'h18, 8'h28, 8'h48, 8'h68, 8'h84, 8'ha4, 8'hc4,
                             8'he4, 8'hf4};
   logic [7:0] inds [4] = '{8'h02, 8'h00, 8'h00, 8'h01};
   logic [12:0] lens [4] = '{13'h0200, 13'h0080, 13'h1000, 13'h0010};

   // ----------------------------------------
   // Clock and instances
   // ----------------------------------------
   always #4 clock = ~clock;

   floppy_command_head_rw_control dut (
      .clock(clock), .resetn(resetn), .clk_en(1'b1), .cmd_wr(cmd_wr), .cmd_word(cmd_word),
      .status_rd(status_rd), .data_wr(data_wr), .data_in(data_in), .data_rd(data_rd),
      .step_done(step_done), .op_done(op_done), .mark_found(mark_found),
      .length_indicator(len_ind), .index_pulse(index_pulse), .ready_in(ready_in),
      .write_protect_n(write_protect_n), .write_fault(write_fault),
      .head_settled_in(head_settled_in), .disk_read_serial_in(rd_dat),
      .external_separator_select(ext_sel), .read_clock_in(rd_clk),
      .head_engage_out(head_engage_out), .write_gate_out(write_gate_out),
      .serial_write_out(serial_write_out), .interrupt_request_out(irq),
      .byte_request_out(req), .status_out(status_out), .data_out(data_out),
      .data_mark_out(data_mark_out), .sector_len_out(sector_len_out),
      .step_rate_select(rate_sel), .data_clock_out(data_clock_out));

   drive_model drive (
      .clock(clock), .resetn(resetn), .head_engage_out(head_engage_out),
      .write_gate_out(write_gate_out), .protect_req(protect_req), .fault_req(fault_req),
      .index_req(index_req), .head_settled_in(head_settled_in),
      .write_protect_n(write_protect_n), .write_fault(write_fault),
      .index_pulse(index_pulse));

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   // Compare and count
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(negedge clock);
   endtask

   // Command write, then let busy land
   task automatic cmd(input logic [7:0] w);
      cmd_word = w;
      cmd_wr = 1'b1;
      tick(1);
      cmd_wr = 1'b0;
      tick(2);
   endtask

   task automatic st_rd;
      status_rd = 1'b1;
      tick(1);
      status_rd = 1'b0;
      tick(1);
   endtask

   task automatic step_pulse;
      step_done = 1'b1;
      tick(1);
      step_done = 1'b0;
      tick(2);
   endtask

   // Bounded wait for byte request
   task automatic wait_req(input int lim);
      for (k = 0; k < lim && req !== 1'b1; k++) tick(1);
   endtask

   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   // ----------------------------------------
   // Watchdog
   // ----------------------------------------
   initial begin
      #200000;
      n_fail++;
      tally_and_finish;
   end

   // ----------------------------------------
   // Test sequence
   // ----------------------------------------
   initial begin
      tick(10);
      check({head_engage_out, write_gate_out, irq, req, status_out}, 16'h0000);
      resetn = 1'b1;
      // Every command word starts busy; force interrupt ends it
      for (i = 0; i < 10; i++) begin
         cmd(codes[i]);
         check(status_out[ST_BUSY], 1'b1);
         cmd(8'hd8);
         check(irq, 1'b1);
         st_rd;
         check({irq, status_out[ST_BUSY]}, 2'b00);
      end
      // Head releases on the third index pulse while idle
      for (i = 1; i <= 3; i++) begin
         index_req = 1'b1;
         tick(1);
         index_req = 1'b0;
         tick(3);
         check(head_engage_out, i < 3);
      end
      // Loaded seek regardless of ready, then verify without load
      ready_in = 1'b0;
      cmd(8'h1b);
      check({head_engage_out, status_out[ST_BUSY]}, 2'b11);
      check(rate_sel, 2'b11);
      step_pulse;
      check({irq, status_out[ST_BUSY]}, 2'b10);
      st_rd;
      cmd(8'h80);
      check({irq, status_out[ST_NRDY], status_out[ST_BUSY]}, 3'b110);
      st_rd;
      ready_in = 1'b1;
      cmd(8'h14);
      check(head_engage_out, 1'b0);
      step_pulse;
      check(head_engage_out, 1'b1);
      cmd(8'hd8);
      st_rd;
      // Engage delay set: no transfer before the settle time
      cmd(8'h84);
      wait_req(1000);
      check(req, 1'b0);
      cmd(8'hd8);
      st_rd;
      // Mark select, sector length and early write gate
      for (i = 0; i < 4; i++) begin
         len_ind = inds[i];
         cmd(8'ha0 | (i < 2 ? 8'h08 : 8'h00) | 8'(i));
         check(data_mark_out, 8'hfb - 8'(i));
         check(sector_len_out, lens[i]);
         wait_req(40);
         check({req, write_gate_out}, 2'b10);
         cmd(8'hd8);
         st_rd;
      end
      // Write one byte, starve the next, then a drive fault
      cmd(8'ha8);
      wait_req(40);
      data_in = 8'ha5;
      data_wr = 1'b1;
      tick(1);
      data_wr = 1'b0;
      tick(2);
      check(write_gate_out, 1'b1);
      // Pulses of the first byte: eight clocks and the ones of the data
      i = int'(serial_write_out);
      for (k = 0; k < 300 && status_out[ST_LOST] !== 1'b1; k++) begin
         tick(1);
         i += int'(serial_write_out);
      end
      check(status_out[ST_LOST], 1'b1);
      check(16'(i), 16'h000c);
      fault_req = 1'b1;
      tick(3);
      check({irq, write_gate_out, status_out[ST_FAULT], status_out[ST_BUSY]}, 4'b1010);
      fault_req = 1'b0;
      st_rd;
      // Write refused on a protected disk
      protect_req = 1'b1;
      cmd(8'ha8);
      check({irq, status_out[ST_PROT], status_out[ST_BUSY], write_gate_out}, 4'b1100);
      st_rd;
      protect_req = 1'b0;
      // Externally separated read, msb first on falling read clock
      ext_sel = 1'b0;
      cmd(8'h88);
      mark_found = 1'b1;
      tick(1);
      mark_found = 1'b0;
      for (i = 7; i >= 0; i--) begin
         rd_dat = 1'(8'h3c >> i);
         tick(2);
         rd_clk = 1'b0;
         tick(2);
         rd_clk = 1'b1;
      end
      wait_req(20);
      check({req, data_out}, 9'h13c);
      data_rd = 1'b1;
      tick(1);
      data_rd = 1'b0;
      tick(1);
      check(req, 1'b0);
      // Data clock keeps running while reading with no transitions
      ext_sel = 1'b1;
      k = 0;
      for (i = 0; i < 40; i++) begin
         dprev = data_clock_out;
         tick(1);
         if (!dprev && data_clock_out) k++;
      end
      check(16'(k), 16'(40 / DATA_CLK_DIV));
      // Sector end reported from outside finishes the read
      op_done = 1'b1;
      tick(1);
      op_done = 1'b0;
      tick(1);
      check({irq, status_out[ST_BUSY]}, 2'b10);
      st_rd;
      tally_and_finish;
   end
endmodule
